/* hw/rhw_pkg.sv */
// Package with register map, field layouts, reset values and shared types for the hour/weekday stage.
package rhw_pkg;

  localparam logic [11:0] HOUR_OFS = 12'h000;
  localparam logic [11:0] WDAY_OFS = 12'h004;
  localparam logic [11:0] CTRL_OFS = 12'h008;
  localparam logic [11:0] MIN_OFS = 12'h00c;

  localparam int BUSY_BIT = 7;
  localparam int CTRL_FMT_BIT = 6;
  localparam int CTRL_PM_BIT = 5;

  localparam logic [1:0] HOUR_TENS_RST = 2'h0;
  localparam logic [3:0] HOUR_ONES_RST = 4'h0;
  localparam logic [2:0] WDAY_RST = 3'h0;
  localparam logic [2:0] WDAY_SAT = 3'h6;
  localparam logic [2:0] WDAY_SUN = 3'h0;
  localparam logic [3:0] MIN_ONES_TOP = 4'h9;
  localparam logic [2:0] MIN_TENS_TOP = 3'h5;

  // Busy lasts this many cycles after each count tick.
  localparam logic [1:0] BUSY_CYCLES = 2'h2;

  typedef struct packed {
    logic [1:0] tens;
    logic [3:0] ones;
  } rhw_bcd_hour_t;

  typedef struct packed {
    logic [2:0] tens;
    logic [3:0] ones;
  } rhw_bcd_min_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } rhw_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rhw_apb_rsp_t;

endpackage

/* hw/rhw_hour_step.sv */
// Combinational BCD hour step with 12/24 wrap and daily carry.
`timescale 1ns/1ps
module rhw_hour_step (
  input wire rhw_pkg::rhw_bcd_hour_t hourIn, // present hour count
  input wire logic fmt24, // 1 selects 24-hour range
  input wire logic afternoonIn, // present afternoon flag
  output rhw_pkg::rhw_bcd_hour_t hourOut, // hour after one hourly carry
  output logic afternoonOut, // afternoon flag after the step
  output logic dayCarry // once-per-day carry
);
  import rhw_pkg::*;

  logic atTop;

  always_comb begin
    atTop = fmt24 ? (hourIn.tens == 2'h2 && hourIn.ones == 4'h3) :
                    (hourIn.tens == 2'h1 && hourIn.ones == 4'h1);
    hourOut = hourIn;
    afternoonOut = afternoonIn;
    dayCarry = 1'b0;
    if (atTop) begin
      hourOut.tens = 2'h0;
      hourOut.ones = 4'h0;
      if (fmt24) begin
        dayCarry = 1'b1;
      end else begin
        afternoonOut = ~afternoonIn;
        dayCarry = afternoonIn;
      end
    end else if (hourIn.ones >= 4'h9) begin
      hourOut.ones = 4'h0;
      hourOut.tens = hourIn.tens + 2'h1;
    end else begin
      hourOut.ones = hourIn.ones + 4'h1;
    end
  end
endmodule

/* hw/rhw_wday_step.sv */
// Combinational weekday step, Sunday through Saturday in binary.
`timescale 1ns/1ps
module rhw_wday_step (
  input wire logic [2:0] dayIn, // present weekday code
  output logic [2:0] dayOut // weekday after one daily carry
);
  import rhw_pkg::*;

  always_comb begin
    if (dayIn >= WDAY_SAT) begin
      dayOut = WDAY_SUN;
    end else begin
      dayOut = dayIn + 3'h1;
    end
  end
endmodule

/* hw/rhw_hour_weekday.sv */
// Hour and weekday counting stages with minute stage, control bits and an APB slave.
`timescale 1ns/1ps
module rhw_hour_weekday (
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic minuteTick, // once-per-minute carry from the seconds stage
  input wire rhw_pkg::rhw_apb_req_t apbReq, // APB request signals
  output rhw_pkg::rhw_apb_rsp_t apbRsp, // APB response signals
  output logic dayCarryOut, // registered daily carry pulse
  output logic updateBusy // update-in-progress level
);
  import rhw_pkg::*;

  typedef struct packed {
    rhw_bcd_min_t minute;
    rhw_bcd_hour_t hour;
    logic [2:0] wday;
    logic fmt24;
    logic afternoon;
    logic [1:0] busyCnt;
    logic dayCarry;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rhw_state_t;

  rhw_state_t state_q;
  rhw_state_t state_d;

  logic hourTick;
  logic dayTick;
  logic accessPhase;
  logic wrEn;
  rhw_bcd_hour_t hourNext;
  logic afternoonNext;
  logic [2:0] wdayNext;

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic [31:0] readMux(input logic [11:0] addr, input rhw_state_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (addr)
      HOUR_OFS: begin
        v[BUSY_BIT] = (s.busyCnt != 2'h0);
        v[5:0] = {s.hour.tens, s.hour.ones};
      end
      WDAY_OFS: begin
        v[BUSY_BIT] = (s.busyCnt != 2'h0);
        v[2:0] = s.wday;
      end
      CTRL_OFS: begin
        v[CTRL_FMT_BIT] = s.fmt24;
        v[CTRL_PM_BIT] = s.afternoon;
      end
      MIN_OFS: begin
        v[BUSY_BIT] = (s.busyCnt != 2'h0);
        v[6:0] = {s.minute.tens, s.minute.ones};
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction

  function automatic logic addrKnown(input logic [11:0] addr);
    return (addr == HOUR_OFS) || (addr == WDAY_OFS) || (addr == CTRL_OFS) ||
           (addr == MIN_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  // Minute wrap drives the hour stage.
  assign hourTick = minuteTick && state_q.minute.ones == MIN_ONES_TOP &&
                    state_q.minute.tens == MIN_TENS_TOP;

  rhw_hour_step u_hour (
    .hourIn(state_q.hour),
    .fmt24(state_q.fmt24),
    .afternoonIn(state_q.afternoon),
    .hourOut(hourNext),
    .afternoonOut(afternoonNext),
    .dayCarry(dayTick)
  );

  rhw_wday_step u_wday (
    .dayIn(state_q.wday),
    .dayOut(wdayNext)
  );

  // Registered slave: pready rises in the second access cycle, one wait state.
  assign accessPhase = apbReq.psel && apbReq.penable && !state_q.pready;
  assign wrEn = accessPhase && apbReq.pwrite && addrKnown(apbReq.paddr);

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    state_d = state_q;
    state_d.dayCarry = 1'b0;
    state_d.pready = 1'b0;
    state_d.pslverr = 1'b0;
    if (state_q.busyCnt != 2'h0) begin
      state_d.busyCnt = state_q.busyCnt - 2'h1;
    end
    if (minuteTick) begin
      state_d.busyCnt = BUSY_CYCLES;
      if (state_q.minute.ones == MIN_ONES_TOP) begin
        state_d.minute.ones = 4'h0;
        if (state_q.minute.tens == MIN_TENS_TOP) begin
          state_d.minute.tens = 3'h0;
        end else begin
          state_d.minute.tens = state_q.minute.tens + 3'h1;
        end
      end else begin
        state_d.minute.ones = state_q.minute.ones + 4'h1;
      end
    end
    if (hourTick) begin
      state_d.hour = hourNext;
      state_d.afternoon = afternoonNext;
      if (dayTick) begin
        state_d.wday = wdayNext;
        state_d.dayCarry = 1'b1;
      end
    end
    // A software write overrides a count in the same cycle.
    if (wrEn) begin
      case (apbReq.paddr)
        HOUR_OFS: begin
          state_d.hour.tens = apbReq.pwdata[5:4];
          state_d.hour.ones = apbReq.pwdata[3:0];
        end
        WDAY_OFS: begin
          state_d.wday = apbReq.pwdata[2:0];
        end
        CTRL_OFS: begin
          state_d.fmt24 = apbReq.pwdata[CTRL_FMT_BIT];
          state_d.afternoon = apbReq.pwdata[CTRL_PM_BIT];
        end
        MIN_OFS: begin
          state_d.minute.tens = apbReq.pwdata[6:4];
          state_d.minute.ones = apbReq.pwdata[3:0];
        end
        default: begin
          state_d.fmt24 = state_q.fmt24;
        end
      endcase
    end
    if (accessPhase) begin
      state_d.pready = 1'b1;
      state_d.pslverr = !addrKnown(apbReq.paddr);
      state_d.prdata = apbReq.pwrite ? 32'h0000_0000 : readMux(apbReq.paddr, state_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign apbRsp.prdata = state_q.prdata;
  assign apbRsp.pready = state_q.pready;
  assign apbRsp.pslverr = state_q.pslverr;
  assign dayCarryOut = state_q.dayCarry;
  assign updateBusy = state_q.busyCnt != 2'h0;

  ////////////////////////////////////////////////////////////////////////////////

  a_hour_ones_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hourTick && !wrEn && state_q.hour.ones == 4'h9) |=> state_q.hour.ones == 4'h0)
    else $error("hour ones did not wrap after nine");

  a_hour_24_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hourTick && !wrEn && state_q.fmt24 && state_q.hour == 6'h23) |=>
    (state_q.hour == 6'h00 && dayCarryOut))
    else $error("24-hour wrap or daily carry missing");

  a_hour_12_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hourTick && !wrEn && !state_q.fmt24 && state_q.hour == 6'h11) |=>
    (state_q.hour == 6'h00 && state_q.afternoon != $past(state_q.afternoon)))
    else $error("12-hour wrap did not toggle afternoon");

  a_hour_step_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hourTick && !wrEn && state_q.hour.ones < 4'h9 && state_q.hour != 6'h11 &&
     state_q.hour != 6'h23) |=> state_q.hour.ones == $past(state_q.hour.ones) + 4'h1)
    else $error("hour did not advance by one");

  a_busy_after_tick: assert property (@(posedge clk_sys) disable iff (!rst_b)
    minuteTick |=> updateBusy [*2])
    else $error("busy flag not held after update");

  a_hour_bit6_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (apbReq.psel && apbReq.penable && !apbReq.pwrite && apbReq.paddr == HOUR_OFS &&
     !state_q.pready) |=> (apbRsp.pready && !apbRsp.prdata[6]))
    else $error("hour bit six read nonzero");

  a_wday_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (apbReq.psel && apbReq.penable && !apbReq.pwrite && apbReq.paddr == WDAY_OFS &&
     !state_q.pready) |=> apbRsp.prdata[6:3] == 4'h0)
    else $error("weekday reserved bits read nonzero");

  a_wday_sat_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hourTick && dayTick && !wrEn && state_q.wday == WDAY_SAT) |=>
    state_q.wday == WDAY_SUN)
    else $error("Saturday did not wrap to Sunday");

  a_wday_no_day_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!(hourTick && dayTick) && !wrEn) |=> $stable(state_q.wday))
    else $error("weekday moved without daily carry");

  a_wday_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_q.wday != 3'h7) |-> ##1 (state_q.wday != 3'h7 || $past(wrEn)))
    else $error("weekday entered reserved code");

  a_tens_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_q.hour.tens != 2'h3) |=> (state_q.hour.tens != 2'h3 || $past(wrEn)))
    else $error("hour tens left range");

  // The busy window is short on purpose, so that a polling read rarely has to retry.
  a_busy_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (minuteTick ##1 !minuteTick ##1 !minuteTick) |=> !updateBusy)
    else $error("busy flag held too long");

  a_busy_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!minuteTick && !updateBusy) |=> !updateBusy)
    else $error("busy flag rose without a tick");

  a_hour_read_busy: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (accessPhase && !apbReq.pwrite && apbReq.paddr == HOUR_OFS) |=>
    (apbRsp.prdata[7] == $past(updateBusy)))
    else $error("hour busy bit disagrees with busy level");

  a_wday_read_busy: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (accessPhase && !apbReq.pwrite && apbReq.paddr == WDAY_OFS) |=>
    (apbRsp.prdata[7] == $past(updateBusy)))
    else $error("weekday busy bit disagrees with busy level");

  a_hour_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (accessPhase && !apbReq.pwrite && apbReq.paddr == HOUR_OFS) |=>
    (apbRsp.prdata[31:8] == 24'h000000))
    else $error("hour upper bits read nonzero");

  a_wday_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (accessPhase && !apbReq.pwrite && apbReq.paddr == WDAY_OFS) |=>
    (apbRsp.prdata[31:8] == 24'h000000))
    else $error("weekday upper bits read nonzero");

  a_day_needs_hour: assert property (@(posedge clk_sys) disable iff (!rst_b)
    dayCarryOut |-> $past(hourTick))
    else $error("daily carry without hourly carry");

  a_hour_no_tick: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!hourTick && !wrEn) |=> $stable(state_q.hour))
    else $error("hour moved without hourly carry");

  a_ones_stay_bcd: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hourTick && !wrEn && state_q.hour.ones <= 4'h9) |=> (state_q.hour.ones <= 4'h9))
    else $error("hour ones left decimal range");

  a_tens_carry: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hourTick && !wrEn && state_q.hour.ones == 4'h9 && state_q.hour.tens < 2'h2) |=>
    (state_q.hour.tens == $past(state_q.hour.tens) + 2'h1))
    else $error("hour tens did not take the carry");

  a_morning_no_day: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hourTick && !wrEn && !state_q.fmt24 && state_q.hour == 6'h11 && !state_q.afternoon)
    |=> !dayCarryOut)
    else $error("daily carry at noon");

  a_evening_day: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hourTick && !wrEn && !state_q.fmt24 && state_q.hour == 6'h11 && state_q.afternoon)
    |=> dayCarryOut)
    else $error("daily carry missing at midnight");

  a_afternoon_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!hourTick && !wrEn) |=> $stable(state_q.afternoon))
    else $error("afternoon flag moved without carry");

endmodule

/* verification/test_rhw_hour_weekday.sv */
// Self-checking bench for the hour and weekday counting stages over APB.
`timescale 1ns/1ps
module test_rhw_hour_weekday;
  import rhw_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic minuteTick = 1'b0;
  rhw_apb_req_t req = '0;
  rhw_apb_rsp_t rsp;
  logic dayCarryOut;
  logic updateBusy;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic serr;
  logic [11:0] ofs [4] = '{HOUR_OFS, WDAY_OFS, CTRL_OFS, MIN_OFS};

  rhw_hour_weekday u_rhw_hour_weekday (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .minuteTick(minuteTick),
    .apbReq(req),
    .apbRsp(rsp),
    .dayCarryOut(dayCarryOut),
    .updateBusy(updateBusy)
  );

  always #50 clk_sys = ~clk_sys;

  // The whole run needs well under a thousand cycles per scenario group.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge clk_sys);
    req <= '{paddr: addr, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wdata};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do @(posedge clk_sys); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    serr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Busy and the daily carry are looked at in the cycle right after the tick.
  task automatic tick(input logic expDay);
    @(posedge clk_sys);
    minuteTick <= 1'b1;
    @(posedge clk_sys);
    minuteTick <= 1'b0;
    #1;
    check({31'h0, updateBusy}, 32'h1);
    check({31'h0, dayCarryOut}, {31'h0, expDay});
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic roll(input logic [7:0] h, input logic [7:0] m, input logic d,
                      input logic [7:0] hExp);
    apb(1'b1, HOUR_OFS, {24'h0, h});
    apb(1'b1, MIN_OFS, {24'h0, m});
    tick(d);
    apb(1'b0, HOUR_OFS, 32'h0);
    check(rd, {24'h0, hExp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      check(rd, 32'h0);
    end
    roll(8'h05, 8'h58, 1'b0, 8'h05);
    apb(1'b0, MIN_OFS, 32'h0);
    check(rd, 32'h59);
    apb(1'b1, CTRL_OFS, 32'h40);
    roll(8'h09, 8'h59, 1'b0, 8'h10);
    roll(8'h11, 8'h59, 1'b0, 8'h12);
    roll(8'h19, 8'h59, 1'b0, 8'h20);
    roll(8'h22, 8'h59, 1'b0, 8'h23);
    // Walk every weekday code through a midnight, Saturday included.
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, WDAY_OFS, i);
      roll(8'h23, 8'h59, 1'b1, 8'h00);
      apb(1'b0, WDAY_OFS, 32'h0);
      check(rd, (i == 6) ? 32'h0 : i + 1);
    end
    apb(1'b0, MIN_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h00);
    roll(8'h10, 8'h59, 1'b0, 8'h11);
    roll(8'h11, 8'h59, 1'b0, 8'h00);
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rd, 32'h20);
    apb(1'b1, WDAY_OFS, 32'h3);
    roll(8'h11, 8'h59, 1'b1, 8'h00);
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, WDAY_OFS, 32'h0);
    check(rd, 32'h4);
    apb(1'b1, HOUR_OFS, 32'hff);
    apb(1'b0, HOUR_OFS, 32'h0);
    check(rd, 32'h3f);
    apb(1'b1, WDAY_OFS, 32'h7e);
    apb(1'b0, WDAY_OFS, 32'h0);
    check(rd, 32'h06);
    // A read whose access lands inside the busy window must show the busy bit.
    fork
      apb(1'b0, HOUR_OFS, 32'h0);
      begin
        @(posedge clk_sys);
        minuteTick <= 1'b1;
        @(posedge clk_sys);
        minuteTick <= 1'b0;
      end
    join
    check(rd, 32'hbf);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0);
    check({31'h0, serr}, 32'h1);
    summarize();
  end
endmodule
